/* File: hw/acc_pkg.sv */
// Constants for the parallel-bus converter conversion control.
// Assumes a single 250 MHz system clock and active-low async reset.
package acc_pkg;

	// System clock period in picoseconds
	localparam int unsigned ACC_CLK_PERIOD_PS = 4000;
	// Longest conversion time, in nanoseconds
	localparam int unsigned ACC_CONV_TIME_NS = 6000;
	// Longest time rounds down to whole cycles
	localparam int unsigned ACC_CONV_CYCLES = (ACC_CONV_TIME_NS * 1000) / ACC_CLK_PERIOD_PS;
	// Result word width
	localparam int unsigned ACC_DATA_W = 10;
	// Successive-approximation steps, one per result bit
	localparam int unsigned ACC_SAR_STEPS = 10;
	// Result latch reset value
	localparam logic [9:0] ACC_RESULT_RST = 10'h000;

	// Converter sequencing states
	typedef enum logic [1:0] {
		ACC_TRACK = 2'b00,
		ACC_HOLD = 2'b01,
		ACC_DONE = 2'b10
	} acc_state_type;

endpackage : acc_pkg

/* File: hw/acc_conv_ctrl.sv */
// Conversion sequencing for a parallel-bus converter mapped as external memory.
// Assumes host strobes arrive asynchronously; sample data from the analog core is synchronous.
// Function
// - Strobes ignored unless chip select low
// - Track from flag fall until next start
// - Write strobe rising edge starts hold, conversion
// - Conversion self-timed from clock
// - Latch result, then drive flag low
// - Read clears flag, drives result out
// - Internally paced conversion completes within 6 us
// - Release data bus after read ends
module acc_conv_ctrl
	import acc_pkg::*;
#(
	parameter int unsigned STEP_CYCLES = 100 // Cycles per approximation step
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic chip_sel_n,
	input wire logic write_n,
	input wire logic read_n,
	input wire logic external_clock_in,
	input wire logic use_ext_clock,
	input wire logic [ACC_DATA_W-1:0] sample_code,
	output logic [ACC_DATA_W-1:0] result_data_bus_o,
	output logic [ACC_DATA_W-1:0] result_data_bus_oe,
	output logic conv_done_n,
	output logic hold_mode
);

	// Ten steps must fit inside the longest conversion time; refused at elaboration
	// The 16-bit step timer never needs to count past this budget either
	if (STEP_CYCLES < 1 || STEP_CYCLES * ACC_SAR_STEPS > ACC_CONV_CYCLES) begin : g_bad_step
		$error("STEP_CYCLES out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: two flops before any logic reads a pin
	logic [3:0] pin_meta_q; // First stage, read only by second
	logic [3:0] pin_sync_q; // cs, wr, rd, ext clock
	logic [3:0] pin_prev_q; // For edge detection
	logic ext_sel_meta_q;
	logic ext_sel_q;

	// Register the pins
	// Idle-high reset values keep a false strobe edge from following reset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= 4'hF;
			pin_sync_q <= 4'hF;
			pin_prev_q <= 4'hF;
			ext_sel_meta_q <= 1'b0;
			ext_sel_q <= 1'b0;
		end else begin
			pin_meta_q <= {external_clock_in, read_n, write_n, chip_sel_n};
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
			ext_sel_meta_q <= use_ext_clock;
			ext_sel_q <= ext_sel_meta_q;
		end
	end

	logic cs_low;
	logic wr_rise;
	logic rd_active;
	logic ext_tick;
	assign cs_low = !pin_sync_q[0];
	// Write edge counts only with chip select low
	assign wr_rise = cs_low && pin_sync_q[1] && !pin_prev_q[1];
	assign rd_active = cs_low && !pin_sync_q[2];
	assign ext_tick = pin_sync_q[3] && !pin_prev_q[3];

	////////////////////////////////////////////////////////////////////////////
	// Conversion sequencer
	acc_state_type state_q, state_d;
	logic [15:0] tick_q, tick_d; // Internal step timer
	logic [3:0] step_q, step_d; // Approximation steps done
	logic [ACC_DATA_W-1:0] result_q, result_d;
	logic done_n_q, done_n_d;
	logic [ACC_DATA_W-1:0] dout_q, dout_d;
	logic [ACC_DATA_W-1:0] oe_q, oe_d;
	logic step_tick;
	logic hold_q, hold_d; // Registered hold indication, drives the pin directly

	// Step pacing: external clock edge or internal divider
	// External pacing relies on the host keeping each level at least four cycles
	assign step_tick = ext_sel_q ? ext_tick : (tick_q == 16'(STEP_CYCLES - 1));

	// Next-state logic
	always_comb begin
		state_d = state_q;
		tick_d = tick_q;
		step_d = step_q;
		result_d = result_q;
		done_n_d = done_n_q;
		dout_d = dout_q;
		oe_d = 10'h000;
		case (state_q)
			ACC_TRACK: begin
				// Sampling until a selected write completes
				if (wr_rise) begin
					state_d = ACC_HOLD;
					tick_d = 16'h0000;
					step_d = 4'h0;
				end
			end
			ACC_HOLD: begin
				// Self-timed; no host action needed
				tick_d = step_tick ? 16'h0000 : tick_q + 16'h0001;
				if (step_tick) begin
					step_d = step_q + 4'h1;
					if (step_q == 4'(ACC_SAR_STEPS - 1)) begin
						result_d = sample_code;
						state_d = ACC_DONE;
					end
				end
			end
			ACC_DONE: begin
				// Flag falls one cycle after the latch loads
				done_n_d = 1'b0;
				state_d = ACC_TRACK;
			end
			default: begin
				state_d = ACC_TRACK;
			end
		endcase
		// Selected read clears flag and drives latch
		// Read wins over a flag set in the same cycle; the data is already on the bus
		if (rd_active) begin
			done_n_d = 1'b1;
			dout_d = result_q;
			oe_d = 10'h3FF;
		end
		// Outside a read the bus floats
		// Hold follows the next state so the pin needs no decode after the flop
		hold_d = (state_d != ACC_TRACK);
	end

	// Register the sequencer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ACC_TRACK;
			tick_q <= 16'h0000;
			step_q <= 4'h0;
			result_q <= ACC_RESULT_RST;
			done_n_q <= 1'b1;
			dout_q <= 10'h000;
			oe_q <= 10'h000;
			hold_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tick_q <= tick_d;
			step_q <= step_d;
			result_q <= result_d;
			done_n_q <= done_n_d;
			dout_q <= dout_d;
			oe_q <= oe_d;
			hold_q <= hold_d;
		end
	end

	assign result_data_bus_o = dout_q;
	assign result_data_bus_oe = oe_q;
	assign conv_done_n = done_n_q;
	assign hold_mode = hold_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	// A counter stands in for a long repetition, which the tools would unroll
	logic [15:0] hold_cnt_q, hold_cnt_d; // Cycles spent in hold

	// Count hold cycles, clear outside hold
	always_comb begin
		hold_cnt_d = (state_q == ACC_HOLD) ? hold_cnt_q + 16'h0001 : 16'h0000;
	end

	// Register the hold counter
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt_q <= 16'h0000;
		end else begin
			hold_cnt_q <= hold_cnt_d;
		end
	end

	// Properties watch registered state in the one clock domain

	cs_gates_bus_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!$past(rd_active) |-> result_data_bus_oe == 10'h000)
		else $error("Bus driven without selected read");
	start_on_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == ACC_TRACK && wr_rise) |=> state_q == ACC_HOLD)
		else $error("Selected write did not start conversion");
	track_stays_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == ACC_TRACK && !wr_rise) |=> state_q == ACC_TRACK)
		else $error("Left track without write");
	conv_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		hold_cnt_q <= 16'(ACC_CONV_CYCLES))
		else $error("Conversion too long");
	latch_then_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(conv_done_n) |-> $past(state_q) == ACC_DONE && result_q == $past(result_q))
		else $error("Flag fell without latched result");
	read_clears_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rd_active |=> conv_done_n && result_data_bus_o == $past(result_q) && result_data_bus_oe == 10'h3FF)
		else $error("Read did not clear flag or drive data");
	release_bus_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(rd_active) |=> result_data_bus_oe == 10'h000)
		else $error("Bus not released after read");
	self_timed_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == ACC_HOLD && !ext_sel_q) |-> ##[1:1000] state_q != ACC_HOLD)
		else $error("Internal conversion stalled");
	flag_stands_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!conv_done_n && !rd_active) |=> !conv_done_n)
		else $error("Flag rose without selected read");
	ext_paced_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == ACC_HOLD && ext_sel_q && !ext_tick) |=> step_q == $past(step_q))
		else $error("Step advanced without external clock edge");
	latch_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == ACC_DONE) |-> result_q == $past(sample_code))
		else $error("Result latch not loaded from core code");

endmodule : acc_conv_ctrl

/* File: verif/acc_host_model.sv */
// Host bus model that drives chip select and the write and read strobes.
// Assumes the converter samples these strobes on sys_clk.
module acc_host_model (
	input wire logic sys_clk,
	output logic chip_sel_n,
	output logic write_n,
	output logic read_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		chip_sel_n = 1'b1;
		write_n = 1'b1;
		read_n = 1'b1;
	end
	// Write cycle; chip select stays until the strobe edge is seen
	task automatic wr(input logic cs_n);
		@(posedge sys_clk) chip_sel_n <= cs_n;
		write_n <= 1'b0;
		repeat (5) @(posedge sys_clk);
		write_n <= 1'b1;
		repeat (5) @(posedge sys_clk);
		chip_sel_n <= 1'b1;
	endtask : wr
	// Read strobe with chip select, as a level
	task automatic rd(input logic lvl_n);
		@(posedge sys_clk) chip_sel_n <= lvl_n;
		read_n <= lvl_n;
	endtask : rd
	// Read strobe alone, chip select left high
	task automatic rd_desel(input logic lvl_n);
		@(posedge sys_clk) read_n <= lvl_n;
	endtask : rd_desel
endmodule : acc_host_model

/* File: verif/test_adc_parallel_conversion_control.sv */
// Testbench: internal and external paced conversions, then read-back.
// Assumes the host model drives strobes; the bench drives the code.
module test_adc_parallel_conversion_control;
	import acc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0, rst_n = 1'b0, ext_clk = 1'b0, use_ext = 1'b0;
	logic cs_n, wr_n, rd_n, done_n, hold;
	logic [ACC_DATA_W-1:0] code = 10'h000, dout, doe;
	int n_fail = 0, num_checks = 0;
	always #2 sys_clk = ~sys_clk;
	// Slow external clock, five system cycles per level
	always begin
		repeat (5) @(posedge sys_clk);
		ext_clk <= ~ext_clk;
	end
	acc_host_model i_host (.sys_clk(sys_clk), .chip_sel_n(cs_n), .write_n(wr_n), .read_n(rd_n));
	acc_conv_ctrl #(.STEP_CYCLES(2)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .chip_sel_n(cs_n), .write_n(wr_n),
		.read_n(rd_n), .external_clock_in(ext_clk), .use_ext_clock(use_ext), .sample_code(code),
		.result_data_bus_o(dout), .result_data_bus_oe(doe), .conv_done_n(done_n), .hold_mode(hold));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	// Idle outputs straight after reset release
	task automatic after_reset();
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1 chk({9'h0, done_n}, 10'h001);
		chk(doe, 10'h000);
		chk({9'h0, hold}, 10'h000);
		$display("reset test done");
	endtask : after_reset
	// Write and read strobes with chip select high must have no effect
	task automatic cs_high();
		i_host.wr(1'b1);
		#1 chk({9'h0, hold}, 10'h000);
		i_host.rd_desel(1'b0);
		repeat (4) @(posedge sys_clk);
		#1 chk(doe, 10'h000);
		chk(dout, 10'h000);
		i_host.rd_desel(1'b1);
		$display("deselected strobe test done");
	endtask : cs_high
	// One conversion, bounded wait, read-back and bus release
	task automatic conv(input logic ext, input logic [9:0] val, input int lo, input int lim);
		int i;
		@(posedge sys_clk) use_ext <= ext;
		code <= val;
		i_host.wr(1'b0);
		#1 chk({9'h0, hold}, 10'h001);
		for (i = 0; i < lim && done_n !== 1'b0; i++) begin
			@(posedge sys_clk);
			#1;
		end
		chk({9'h0, done_n}, 10'h000);
		chk({9'h0, (i >= lo)}, 10'h001);
		if (done_n === 1'b0) begin
			i_host.rd(1'b0);
			repeat (4) @(posedge sys_clk);
			#1 chk(dout, val);
			chk(doe, 10'h3FF);
			chk({9'h0, done_n}, 10'h001);
			i_host.rd(1'b1);
			repeat (4) @(posedge sys_clk);
			#1 chk(doe, 10'h000);
			chk({9'h0, hold}, 10'h000);
		end
		$display("conversion test done");
	endtask : conv
	initial begin
		after_reset();
		cs_high();
		conv(1'b0, 10'h2A5, 15, 60);
		conv(1'b1, 10'h15A, 80, 250);
		end_of_test();
	end
endmodule : test_adc_parallel_conversion_control
